// ### spcr_pkg.sv
package spcr_pkg;
   // Register addresses (13-bit address field of the instruction word)
   localparam logic [12:0] ADDR_SETUP = 13'h0000;
   localparam logic [12:0] ADDR_IDENT = 13'h0003;
   localparam logic [12:0] ADDR_RBSEL = 13'h0004;
   localparam logic [12:0] ADDR_UPDATE = 13'h0232;
   // Field positions in the setup, readback select and update bytes
   localparam int BIT_SEP_OUT = 0;
   localparam int BIT_LSB_FIRST = 1;
   localparam int BIT_SOFT_RST = 2;
   localparam int BIT_LONG_INSTR = 3;
   localparam int BIT_RBSEL = 0;
   localparam int BIT_UPDATE = 0;
   // Reset values
   localparam logic [7:0] SETUP_RST = 8'h18;
   localparam logic [7:0] RBSEL_RST = 8'h00;
   // Identity value, arbitrary
   localparam logic [7:0] VARIANT_ID = 8'h5A;
   // Frame layout
   localparam logic [4:0] INSTR_BITS = 5'h10;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   localparam int ADDR_W = 13;
endpackage : spcr_pkg

// ### spcr_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Writing soft reset bit 2 high restores readback select and active copies to defaults; bit does not self-clear.
// - Bit order zero: MSB first, address decrements; one: LSB first, increments.
// - Separate output off: reads drive the data pin, serial output stays undriven.
// - Separate output on: reads go out on serial output, writes on data pin.
// - Read-only identity byte at address 0x003.
// - Readback select at 0x004 picks buffered (0) or active (1) copy.
// - Self-clearing update bit at 0x232 copies buffered into active registers.
module spcr_regs (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic serial_out_pin,
   output logic serial_out_oe,
   output logic [7:0] active_setup,
   output logic active_readback_sel
);
   // Link-side state, clocked by sclk; frame state reset while cs_n is high, buffered registers by rst_n
   logic [15:0] sh_r, sh_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic rd_r, rd_nxt;
   logic [12:0] addr_r, addr_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [7:0] buf_setup_r, buf_setup_nxt;
   logic [7:0] buf_rbsel_r, buf_rbsel_nxt;
   logic upd_tgl_r, upd_tgl_nxt;
   logic out_bit_r, out_bit_nxt;
   logic drv_r, drv_nxt;
   // Core-side state, plus the sclk-side reset and readback synchronisers
   logic [2:0] upd_sync_r, upd_sync_nxt;
   logic [7:0] act_setup_r, act_setup_nxt;
   logic [7:0] act_rbsel_r, act_rbsel_nxt;
   logic [1:0] rst_sync_r, rst_sync_nxt;
   logic [1:0] soft_sync_r, soft_sync_nxt;
   logic [7:0] act_setup_s1_r, act_setup_s2_r;
   logic [7:0] act_rbsel_s1_r, act_rbsel_s2_r;

   // Read mux selecting buffered or active copy
   function automatic logic [7:0] spcr_rd(input logic [12:0] a, input logic [7:0] bs,
                                         input logic [7:0] br, input logic [7:0] as_,
                                         input logic [7:0] ar);
      logic use_act;
      use_act = br[spcr_pkg::BIT_RBSEL];
      case (a)
         spcr_pkg::ADDR_SETUP: spcr_rd = use_act ? as_ : bs;
         spcr_pkg::ADDR_IDENT: spcr_rd = spcr_pkg::VARIANT_ID;
         spcr_pkg::ADDR_RBSEL: spcr_rd = use_act ? ar : br;
         default: spcr_rd = 8'h00;
      endcase
   endfunction : spcr_rd

   // Soft reset level held in the buffered setup byte
   logic soft_rst;
   assign soft_rst = buf_setup_r[spcr_pkg::BIT_SOFT_RST];
   logic lsb_first;
   assign lsb_first = buf_setup_r[spcr_pkg::BIT_LSB_FIRST];
   logic [7:0] rx_byte;
   // LSB-first bits enter at the top of the shifter, so the first seven sit in 15:9
   assign rx_byte = lsb_first ? {sdio_i, sh_r[15:9]} : {sh_r[6:0], sdio_i};

   // Link next-state logic on each sampled bit
   always_comb begin
      sh_nxt = {sh_r[14:0], sdio_i};
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      rd_nxt = rd_r;
      addr_nxt = addr_r;
      buf_setup_nxt = buf_setup_r;
      buf_rbsel_nxt = buf_rbsel_r;
      upd_tgl_nxt = upd_tgl_r;
      if (cnt_r < spcr_pkg::INSTR_BITS) begin
         cnt_nxt = cnt_r + 5'h01;
         if (lsb_first) begin
            sh_nxt = {sdio_i, sh_r[15:1]};
         end
         if (cnt_r == spcr_pkg::INSTR_BITS - 5'h01) begin
            // Instruction complete: R/W, W1:W0, 13-bit address
            if (lsb_first) begin
               rd_nxt = sdio_i;
               addr_nxt = sh_r[13:1];
            end else begin
               rd_nxt = sh_r[14];
               addr_nxt = {sh_r[11:0], sdio_i};
            end
            bit_nxt = 3'h0;
         end
      end else begin
         sh_nxt = lsb_first ? {sdio_i, sh_r[15:1]} : {sh_r[14:0], sdio_i};
         bit_nxt = bit_r + 3'h1;
         if (bit_r == spcr_pkg::BYTE_LAST) begin
            if (!rd_r) begin
               case (addr_r)
                  spcr_pkg::ADDR_SETUP: buf_setup_nxt = rx_byte;
                  spcr_pkg::ADDR_RBSEL: buf_rbsel_nxt = rx_byte;
                  spcr_pkg::ADDR_UPDATE: begin
                     if (rx_byte[spcr_pkg::BIT_UPDATE]) begin
                        upd_tgl_nxt = ~upd_tgl_r;
                     end
                  end
                  default: ;
               endcase
            end
            addr_nxt = lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
         end
      end
      if (soft_rst) begin
         buf_rbsel_nxt = spcr_pkg::RBSEL_RST;
      end
   end

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         sh_r <= 16'h0000;
         cnt_r <= 5'h00;
         bit_r <= 3'h0;
         rd_r <= 1'b0;
         addr_r <= 13'h0000;
      end else begin
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         rd_r <= rd_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Buffered registers persist across frames
   always_ff @(posedge sclk) begin
      if (!rst_sync_r[1]) begin
         buf_setup_r <= spcr_pkg::SETUP_RST;
         buf_rbsel_r <= spcr_pkg::RBSEL_RST;
         upd_tgl_r <= 1'b0;
      end else begin
         buf_setup_r <= buf_setup_nxt;
         buf_rbsel_r <= buf_rbsel_nxt;
         upd_tgl_r <= upd_tgl_nxt;
      end
   end

   // Read data shifted out on falling edge
   always_comb begin
      tx_nxt = tx_r;
      out_bit_nxt = out_bit_r;
      drv_nxt = 1'b0;
      if (rd_r && cnt_r == spcr_pkg::INSTR_BITS) begin
         drv_nxt = 1'b1;
         if (bit_r == 3'h0) begin
            tx_nxt = spcr_rd(addr_r, buf_setup_r, buf_rbsel_r, act_setup_s2_r, act_rbsel_s2_r);
         end else begin
            tx_nxt = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
         end
         out_bit_nxt = lsb_first ? tx_nxt[0] : tx_nxt[7];
      end
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         tx_r <= 8'h00;
         out_bit_r <= 1'b0;
         drv_r <= 1'b0;
      end else begin
         tx_r <= tx_nxt;
         out_bit_r <= out_bit_nxt;
         drv_r <= drv_nxt;
      end
   end

   // Pin steering by the separate-output select
   logic sep_out;
   assign sep_out = buf_setup_r[spcr_pkg::BIT_SEP_OUT];
   assign sdio_o = out_bit_r;
   assign sdio_oe = drv_r && !sep_out;
   assign serial_out_pin = out_bit_r;
   assign serial_out_oe = drv_r && sep_out;

   // Core side: sync update toggle, soft reset, and reset for link domain
   always_comb begin
      upd_sync_nxt = {upd_sync_r[1:0], upd_tgl_r};
      act_setup_nxt = act_setup_r;
      act_rbsel_nxt = act_rbsel_r;
      rst_sync_nxt = {rst_sync_r[0], 1'b1};
      soft_sync_nxt = {soft_sync_r[0], soft_rst};
      if (upd_sync_r[2] != upd_sync_r[1]) begin
         act_setup_nxt = buf_setup_r;
         act_rbsel_nxt = buf_rbsel_r;
      end
      // Soft reset also restores the active copies and wins over an update
      if (soft_sync_r[1]) begin
         act_setup_nxt = spcr_pkg::SETUP_RST;
         act_rbsel_nxt = spcr_pkg::RBSEL_RST;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         upd_sync_r <= 3'h0;
         soft_sync_r <= 2'h0;
         act_setup_r <= spcr_pkg::SETUP_RST;
         act_rbsel_r <= spcr_pkg::RBSEL_RST;
      end else begin
         upd_sync_r <= upd_sync_nxt;
         soft_sync_r <= soft_sync_nxt;
         act_setup_r <= act_setup_nxt;
         act_rbsel_r <= act_rbsel_nxt;
      end
   end

   // Reset release synchronised into the link domain
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= rst_sync_nxt;
      end
   end

   // Active copy into link domain for readback, two stages
   always_ff @(posedge sclk) begin
      act_setup_s1_r <= act_setup_r;
      act_setup_s2_r <= act_setup_s1_r;
      act_rbsel_s1_r <= act_rbsel_r;
      act_rbsel_s2_r <= act_rbsel_s1_r;
   end

   assign active_setup = act_setup_r;
   assign active_readback_sel = act_rbsel_r[spcr_pkg::BIT_RBSEL];
endmodule : spcr_regs

// ### spcr_chk_sva.sv
`timescale 1ns/1ps
module spcr_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sdio_oe,
   input wire logic serial_out_oe,
   input wire logic [7:0] active_setup,
   input wire logic active_readback_sel
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Both output enables low for eight cycles; port deselected for eight cycles
   sequence quiet8; (!sdio_oe && !serial_out_oe) [*8]; endsequence
   sequence idle8; cs_n [*8]; endsequence
   oe_excl_a: assert property (!(sdio_oe && serial_out_oe)) else $error("two read drivers");
   sdio_frame_a: assert property (sdio_oe |-> !cs_n) else $error("data pin driven idle");
   sout_frame_a: assert property (serial_out_oe |-> !cs_n) else $error("serial out driven idle");
   oe_idle_a: assert property (cs_n && $past(cs_n) |-> !sdio_oe && !serial_out_oe) else $error("oe not off");
   instr_quiet_a: assert property ($fell(cs_n) |-> quiet8) else $error("driven in instruction");
   active_rst_a: assert property ($rose(rst_n) |-> active_setup == spcr_pkg::SETUP_RST && !active_readback_sel)
      else $error("active rst");
   active_hold_a: assert property (idle8 |=> $stable(active_setup) && $stable(active_readback_sel)) else $error("drift");
   mirror_ok_a: assert property (active_setup[7:4] == {active_setup[0], active_setup[1], active_setup[2],
      active_setup[3]}) else $error("active setup torn");
endmodule : spcr_chk
bind spcr_regs spcr_chk i_spcr_chk (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sdio_oe(sdio_oe),
   .serial_out_oe(serial_out_oe), .active_setup(active_setup), .active_readback_sel(active_readback_sel));

// ### spcr_host.sv
`timescale 1ns/1ps
module spcr_host (
   output logic sclk,
   output logic cs_n,
   output logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire logic serial_out_pin,
   input wire logic serial_out_oe
);
   logic drv = 1'b0;
   logic lsb_r = 1'b0;
   logic sep_r = 1'b0;
   // Shared data pin: device wins while it drives
   assign sdio_i = sdio_oe ? sdio_o : drv;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   // Deselected clocking, needed only around reset
   task automatic idle(input int n);
      repeat (2 * n) #15 sclk = ~sclk;
   endtask : idle
   // Instruction then n bytes; drive after falling edge, sample at rising
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [15:0] d, input int n, output logic [15:0] q);
      logic [31:0] s;
      int p;
      s = {rd, 2'b00, a, d};
      cs_n = 1'b0;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         p = i < 16 ? (lsb_r ? 16 + i : 31 - i) : 8 * (3 - i / 8) + (lsb_r ? i % 8 : 7 - i % 8);
         drv = (rd && i >= 16) ? ~drv : s[p];
         #15 sclk = 1'b1;
         // A released output pin shows the toggling host level, never a stale bit
         if (rd && i >= 16) s[p] = sep_r ? (serial_out_oe ? serial_out_pin : drv) : sdio_i;
         #15 sclk = 1'b0;
      end
      #15 cs_n = 1'b1;
      drv = ~drv;
      if (!rd && a == 13'h000) {lsb_r, sep_r} = d[9:8];
      q = s[15:0];
      // Deselect gap so the next frame never starts in the same time step
      #15;
   endtask : xfer
endmodule : spcr_host

// ### spcr_regs_bench.sv
`timescale 1ns/1ps
module spcr_regs_bench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, cs_n, sdio_i, sdio_o, sdio_oe, serial_out_pin, serial_out_oe, active_readback_sel;
   logic [7:0] active_setup;
   logic [15:0] seen, q;
   logic [15:0] exp_q[$];
   logic [12:0] ra;
   integer seed = 32'h6F078A15;
   int bad_count = 0;
   int samples_checked = 0;
   event got;
   always #5 core_clk = ~core_clk;
   spcr_regs i_spcr_regs (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
      .active_setup(active_setup), .active_readback_sel(active_readback_sel));
   spcr_host i_spcr_host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
   // Oldest expectation against each result
   always @(got) begin
      samples_checked++;
      if (seen !== exp_q[0]) begin
         bad_count++;
         $display("[FAIL] readback exp %h got %h", exp_q[0], seen);
      end
      void'(exp_q.pop_front());
   end
   task automatic tally_and_finish();
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      i_spcr_host.xfer(1'b0, a, {v, 8'h00}, 1, q);
   endtask : wr
   // Two-byte read from a and its neighbour
   task automatic chk(input logic [12:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      i_spcr_host.xfer(1'b1, a, 16'h0000, 2, q);
      seen = q;
      ->got;
   endtask : chk
   // Active copies after an update or soft reset has crossed
   task automatic flag(input logic e, input logic [7:0] s);
      repeat (10) @(negedge core_clk);
      exp_q.push_back({s, 7'h00, e});
      seen = {active_setup, 7'h00, active_readback_sel};
      ->got;
   endtask : flag
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      fork
         i_spcr_host.idle(1);
      join_none
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      i_spcr_host.idle(1);
      chk(13'h004, {8'h00, spcr_pkg::VARIANT_ID});
      chk(13'h000, {8'h18, 8'h00});
      ra = 13'h0100 + 13'($random(seed) & 32'hFF);
      wr(ra, 8'($random(seed)));
      chk(ra, 16'h0000);
      wr(13'h004, 8'h01);
      wr(13'h003, 8'hFF);
      // Buffered select is one, so the 0x004 byte comes from the active side; 0x003 is the fixed identity
      chk(13'h004, {8'h00, spcr_pkg::VARIANT_ID});
      flag(1'b0, spcr_pkg::SETUP_RST);
      wr(13'h000, 8'h3C);
      chk(13'h000, {8'h3C, 8'h00});
      wr(13'h000, 8'h18);
      chk(13'h004, {8'h00, spcr_pkg::VARIANT_ID});
      wr(13'h004, 8'h01);
      wr(13'h232, 8'h01);
      flag(1'b1, spcr_pkg::SETUP_RST);
      wr(13'h004, 8'h00);
      // Buffered select back at zero: buffered zero, not the active one
      chk(13'h004, {8'h00, spcr_pkg::VARIANT_ID});
      wr(13'h232, 8'h01);
      flag(1'b0, spcr_pkg::SETUP_RST);
      wr(13'h000, 8'h99);
      chk(13'h004, {8'h00, spcr_pkg::VARIANT_ID});
      wr(13'h000, 8'h5A);
      wr(13'h004, 8'h01);
      chk(13'h003, {spcr_pkg::VARIANT_ID, 8'h00});
      wr(13'h232, 8'h01);
      flag(1'b1, 8'h5A);
      // Soft reset written LSB first; the mirrored byte reads the same either way
      wr(13'h000, 8'h3C);
      flag(1'b0, spcr_pkg::SETUP_RST);
      wr(13'h000, 8'h18);
      chk(13'h000, {8'h18, 8'h00});
      // Let the watcher take the last result before the verdict
      repeat (2) @(negedge core_clk);
      tally_and_finish();
   end
endmodule : spcr_regs_bench
